// ### src/cvt_dual_link.sv
`timescale 1ns/1ns
`include "cvt_map.svh"
module cvt_dual_link #(
	parameter int DLY_DEPTH = 16
) (
	input wire logic core_clk, // sample clock
	input wire logic resetn, // async reset
	input wire logic [3:0] regAddr, // register index
	input wire logic [15:0] regWdata, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [15:0] regRdata, // read data, next cycle
	input wire logic inValid, // input sample valid
	input wire logic [9:0] inLuma, // input luma
	input wire logic [9:0] inChroma, // input Cb or Cr
	input wire logic inCbFlag, // chroma is Cb
	input wire logic inFieldStart, // first sample of field
	input wire logic inLock, // input present
	input wire cvt_pkg::cvt_fmt_t inFormat, // detected format
	output logic linkAValid, // primary link valid
	output logic [23:0] linkAData, // primary: ch0, ch1
	output logic linkBValid, // secondary link valid
	output logic [23:0] linkBData, // secondary: ch2, alpha
	output logic [7:0] pidA, // primary payload id
	output logic [7:0] pidB, // secondary payload id
	output logic [3:0] audMaskA, // audio groups on primary
	output logic [3:0] audMaskB, // audio groups on secondary
	output logic ancOnB, // ancillary on secondary
	output logic frameStart, // output frame start
	output logic progOut, // progressive doubling active
	output logic [11:0] hScroll, // horizontal offset
	output logic [11:0] vScroll, // vertical offset
	output logic [11:0] gradH, // horizontal gradient start
	output logic [11:0] gradV, // vertical gradient start
	output logic patternProj // projector pattern set
);
	import cvt_pkg::*;

	typedef struct packed {
		logic convEn;
		logic lumaAll;
		cvt_aud_t aud;
		logic proj;
		logic rnd;
		logic [3:0] alphaSel;
		cvt_fmt_t fmt;
		cvt_smp_t reqSt;
		cvt_smp_t effSt;
		logic signed [4:0] skew;
		logic signed [8:0] hStep;
		logic signed [8:0] vStep;
		logic [4:0] period;
		logic [11:0] gradH;
		logic [11:0] gradV;
		logic noIn;
		logic fmtErr;
		logic lumaRef;
		logic parity;
		logic [4:0] frmCnt;
		logic [11:0] hOff;
		logic [11:0] vOff;
		logic [15:0] lfsr;
		logic [8:0][9:0] chH;
		logic [8:0] cbH;
		logic [4:0][9:0] yH;
		logic [DLY_DEPTH-1:0][48:0] dly;
		logic [15:0] rdata;
		logic aValid;
		logic bValid;
		logic [23:0] aData;
		logic [23:0] bData;
		logic [7:0] pidA;
		logic [7:0] pidB;
		logic [3:0] audA;
		logic [3:0] audB;
		logic ancB;
		logic frame;
		logic prog;
	} cvt_state_t;

	cvt_state_t s_q, s_d;

	function automatic logic [11:0] clamp12(input int v);
		if (v < 0)
			return 12'h000;
		if (v > 4095)
			return 12'hFFF;
		return 12'(v);
	endfunction

	// four-tap half-band, scaled so two extra low bits survive
	function automatic logic [11:0] interp(input logic [9:0] a, input logic [9:0] b,
		input logic [9:0] c, input logic [9:0] d);
		int v;
		v = 9 * (int'(b) + int'(c)) - int'(a) - int'(d);
		return clamp12(v >>> 2);
	endfunction

	function automatic int clampS(input int v, input int lim);
		if (v > lim)
			return lim;
		if (v < -lim)
			return -lim;
		return v;
	endfunction

	function automatic logic isProgFmt(input cvt_fmt_t f);
		return f == CVT_F_P60 || f == CVT_F_P5994 || f == CVT_F_P50;
	endfunction

	function automatic logic is2k(input cvt_fmt_t f);
		return f == CVT_F_2K1080 || f == CVT_F_2K1556;
	endfunction

	logic prog, single2, lumaOn, advance;
	logic [11:0] y12, cb12, cr12, c0, c1, c2, alpha;
	logic [4:0] aIdx, bIdx;
	cvt_fmt_t expFmt;
	cvt_smp_t eff;
	int cb, cr, rr, gg, bb, tmp, lim;

	always_comb begin
		s_d = s_q;
		tmp = 0;
		lim = 0;
		s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};
		if (regWr) begin
			unique case (regAddr)
				`CVT_A_CTRL: begin
					s_d.convEn = regWdata[`CVT_B_CONV];
					s_d.lumaAll = regWdata[`CVT_B_LUMA];
					if (regWdata[`CVT_B_AUD+1 -: 2] <= 2'(CVT_AUD_AB))
						s_d.aud = cvt_aud_t'(regWdata[`CVT_B_AUD+1 -: 2]);
					// projector set only exists in the 2K formats
					s_d.proj = regWdata[`CVT_B_PROJ] && is2k(s_q.fmt);
					s_d.rnd = regWdata[`CVT_B_RND];
					if (regWdata[`CVT_B_ALPHA+3 -: 4] <= 4'hB)
						s_d.alphaSel = regWdata[`CVT_B_ALPHA+3 -: 4];
					if (regWdata[`CVT_B_CONV] && !s_q.convEn)
						s_d.proj = 1'b0;
				end
				`CVT_A_FMT: begin
					if (regWdata[3:0] <= 4'(CVT_F_2K1556))
						s_d.fmt = cvt_fmt_t'(regWdata[3:0]);
					if (regWdata[7:4] <= 4'(CVT_S_XYZ12))
						s_d.reqSt = cvt_smp_t'(regWdata[7:4]);
				end
				`CVT_A_SKEW:
					s_d.skew = 5'(clampS(int'($signed(regWdata[4:0])), `CVT_SKEW_MAX));
				`CVT_A_HSTEP:
					// round before clamping so -254 cannot round past the limit
					s_d.hStep = 9'(clampS(int'($signed(regWdata[8:0] & 9'h1FC)), `CVT_SCR_MAX));
				`CVT_A_VSTEP:
					s_d.vStep = 9'(clampS(int'($signed(regWdata[8:0])), `CVT_SCR_MAX));
				`CVT_A_PERIOD: begin
					tmp = int'(regWdata[4:0]);
					s_d.period = tmp < 1 ? 5'd1 : (tmp > `CVT_PER_MAX ? 5'(`CVT_PER_MAX) : 5'(tmp));
				end
				`CVT_A_GRADH: begin
					tmp = int'(regWdata[11:0]);
					tmp = tmp < `CVT_GRAD_MIN ? `CVT_GRAD_MIN : tmp;
					s_d.gradH = 12'(tmp > `CVT_GRADH_MAX ? `CVT_GRADH_MAX : tmp);
				end
				`CVT_A_GRADV: begin
					tmp = int'(regWdata[11:0]);
					lim = s_q.fmt == CVT_F_2K1556 ? `CVT_GRADV_1556 : `CVT_GRADV_1080;
					tmp = tmp < `CVT_GRAD_MIN ? `CVT_GRAD_MIN : tmp;
					s_d.gradV = 12'(tmp > lim ? lim : tmp);
				end
				default: ;
			endcase
		end
		if (!is2k(s_d.fmt))
			s_d.proj = 1'b0;
		if (s_d.fmt == CVT_F_2K1556 && s_d.gradV > 12'(`CVT_GRADV_1556))
			s_d.gradV = 12'(`CVT_GRADV_1556);

		// effective sample structure
		eff = s_q.reqSt;
		if (isProgFmt(s_q.fmt))
			eff = CVT_S_YCC422_10;
		else if (is2k(s_q.fmt))
			eff = (s_q.proj || s_q.reqSt == CVT_S_XYZ12) ? CVT_S_XYZ12 : CVT_S_GBR12;
		else if (s_q.reqSt == CVT_S_XYZ12)
			eff = CVT_S_GBR12;
		s_d.effSt = eff;
		s_d.lumaRef = s_q.lumaAll && !(s_q.effSt inside {CVT_S_GBR12, CVT_S_GBR10, CVT_S_GBRA10});
		lumaOn = s_q.lumaAll && !s_d.lumaRef;
		prog = isProgFmt(s_q.fmt);
		single2 = !prog && s_q.effSt == CVT_S_YCC422_10;

		// input checks
		unique case (s_q.fmt)
			CVT_F_P60: expFmt = CVT_F_I60;
			CVT_F_P5994: expFmt = CVT_F_I5994;
			CVT_F_P50: expFmt = CVT_F_I50;
			CVT_F_2K1080, CVT_F_2K1556: expFmt = CVT_F_PLOW;
			default: expFmt = s_q.fmt;
		endcase
		s_d.noIn = s_q.convEn && !inLock;
		s_d.fmtErr = s_q.convEn && inLock && inFormat != expFmt;

		// sample history
		if (inValid) begin
			s_d.chH = {s_q.chH[7:0], inChroma};
			s_d.cbH = {s_q.cbH[7:0], inCbFlag};
			s_d.yH = {s_q.yH[3:0], inLuma};
		end
		y12 = {s_q.yH[4], 2'b00};
		if (s_q.cbH[4]) begin
			cb12 = {s_q.chH[4], 2'b00};
			cr12 = {s_q.chH[3], 2'b00};
		end else begin
			cb12 = interp(s_q.chH[7], s_q.chH[5], s_q.chH[3], s_q.chH[1]);
			cr12 = interp(s_q.chH[6], s_q.chH[4], s_q.chH[2], s_q.chH[0]);
		end
		cb = int'(cb12) - `CVT_CHR_MID;
		cr = int'(cr12) - `CVT_CHR_MID;
		rr = int'(y12) + ((`CVT_K_RCR * cr) >>> 10);
		gg = int'(y12) - ((`CVT_K_GCB * cb + `CVT_K_GCR * cr) >>> 10);
		bb = int'(y12) + ((`CVT_K_BCB * cb) >>> 10);
		rr = int'(clamp12(rr));
		gg = int'(clamp12(gg));
		bb = int'(clamp12(bb));
		unique case (s_q.effSt)
			CVT_S_GBR12, CVT_S_GBR10, CVT_S_GBRA10: begin
				c0 = clamp12(gg);
				c1 = clamp12(bb);
				c2 = clamp12(rr);
			end
			CVT_S_YCC444_12, CVT_S_YCC444_10, CVT_S_YCCA444_10: begin
				c0 = y12;
				c1 = cb12;
				c2 = cr12;
			end
			CVT_S_XYZ12: begin
				// linear matrix only; cinema gamma curve is not modelled
				c0 = clamp12((`CVT_XR * rr + `CVT_XG * gg + `CVT_XB * bb) >>> 10);
				c1 = clamp12((`CVT_YR * rr + `CVT_YG * gg + `CVT_YB * bb) >>> 10);
				c2 = clamp12((`CVT_ZR * rr + `CVT_ZG * gg + `CVT_ZB * bb) >>> 10);
			end
			default: begin
				c0 = y12;
				c1 = {s_q.chH[4], 2'b00};
				c2 = `CVT_BLANK;
			end
		endcase
		if (lumaOn) begin
			c0 = y12;
			c1 = y12;
			c2 = y12;
		end
		if (s_q.effSt inside {CVT_S_GBR10, CVT_S_GBRA10, CVT_S_YCC444_10, CVT_S_YCCA444_10}) begin
			c0[1:0] = 2'b00;
			c1[1:0] = 2'b00;
			c2[1:0] = 2'b00;
		end
		if (!(s_q.effSt inside {CVT_S_GBRA10, CVT_S_YCCA444_10, CVT_S_YCCA422_12}))
			alpha = `CVT_BLANK;
		else if (s_q.alphaSel == 4'h0)
			alpha = c0;
		else
			alpha = 12'(int'(`CVT_BLANK) + (`CVT_FLAT_SPAN * (int'(s_q.alphaSel) - 1)) / 10);

		// mix word and skew line
		s_d.dly = {s_q.dly[DLY_DEPTH-2:0], 49'h0};
		if (prog || single2)
			s_d.dly[0] = {inValid && s_q.convEn, inLuma, 2'b00, inChroma, 2'b00,
				prog ? {inLuma, 2'b00, inChroma, 2'b00} : {2{`CVT_BLANK}}};
		else
			s_d.dly[0] = {inValid && s_q.convEn, c0, c1, c2, alpha};
		aIdx = s_q.skew < 0 ? 5'(-int'(s_q.skew) * `CVT_SKEW_CYC) : 5'h00;
		bIdx = s_q.skew > 0 ? 5'(int'(s_q.skew) * `CVT_SKEW_CYC) : 5'h00;
		s_d.aValid = s_q.dly[aIdx][48];
		s_d.aData = s_q.dly[aIdx][47:24];
		s_d.bValid = s_q.dly[bIdx][48] && !single2;
		s_d.bData = s_q.dly[bIdx][23:0];

		s_d.pidA = single2 ? `CVT_PID_SINGLE : `CVT_PID_DUAL;
		s_d.pidB = single2 ? `CVT_PID_SINGLE : `CVT_PID_DUAL;
		s_d.ancB = !single2;
		if (single2 || prog) begin
			s_d.audA = 4'hF;
			s_d.audB = prog ? 4'hF : 4'h0;
		end else begin
			unique case (s_q.aud)
				CVT_AUD_A: {s_d.audA, s_d.audB} = {4'h3, 4'hC};
				CVT_AUD_B: {s_d.audA, s_d.audB} = {4'h0, 4'h3};
				default: {s_d.audA, s_d.audB} = {4'h3, 4'h3};
			endcase
		end

		// each field is a frame when doubling
		if (inFieldStart)
			s_d.parity = !s_q.parity;
		s_d.frame = s_q.convEn && inFieldStart && (prog || s_q.parity);
		s_d.prog = s_q.convEn && prog;
		advance = 1'b0;
		if (s_q.frame) begin
			advance = s_q.frmCnt + 5'd1 >= s_q.period;
			s_d.frmCnt = advance ? 5'd0 : s_q.frmCnt + 5'd1;
		end
		if (advance) begin
			if (s_q.rnd) begin
				s_d.hOff = s_q.hOff + 12'({{3{s_q.lfsr[6]}}, s_q.lfsr[6:0], 2'b00});
				s_d.vOff = s_q.vOff + 12'({{4{s_q.lfsr[15]}}, s_q.lfsr[15:8]});
			end else begin
				s_d.hOff = s_q.hOff + 12'({{3{s_q.hStep[8]}}, s_q.hStep});
				s_d.vOff = s_q.vOff + 12'({{3{s_q.vStep[8]}}, s_q.vStep});
			end
		end

		s_d.rdata = 16'h0000;
		if (regRd) begin
			unique case (regAddr)
				`CVT_A_CTRL: s_d.rdata = 16'({s_q.alphaSel, s_q.rnd, s_q.proj, s_q.aud, s_q.lumaAll, s_q.convEn});
				`CVT_A_FMT: s_d.rdata = 16'({s_q.reqSt, s_q.fmt});
				`CVT_A_SKEW: s_d.rdata = 16'({{11{s_q.skew[4]}}, s_q.skew});
				`CVT_A_HSTEP: s_d.rdata = 16'({{7{s_q.hStep[8]}}, s_q.hStep});
				`CVT_A_VSTEP: s_d.rdata = 16'({{7{s_q.vStep[8]}}, s_q.vStep});
				`CVT_A_PERIOD: s_d.rdata = 16'(s_q.period);
				`CVT_A_GRADH: s_d.rdata = 16'(s_q.gradH);
				`CVT_A_GRADV: s_d.rdata = 16'(s_q.gradV);
				`CVT_A_STATUS: s_d.rdata = 16'({s_q.effSt, s_q.lumaRef, s_q.fmtErr, s_q.noIn});
				default: s_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.fmt <= CVT_F_I5994;
			s_q.reqSt <= CVT_S_GBR12;
			s_q.effSt <= CVT_S_GBR12;
			s_q.period <= `CVT_RST_PERIOD;
			s_q.gradH <= `CVT_RST_GRAD;
			s_q.gradV <= `CVT_RST_GRAD;
			s_q.lfsr <= `CVT_LFSR_SEED;
			s_q.pidA <= `CVT_PID_DUAL;
			s_q.pidB <= `CVT_PID_DUAL;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdata = s_q.rdata;
	assign linkAValid = s_q.aValid;
	assign linkAData = s_q.aData;
	assign linkBValid = s_q.bValid;
	assign linkBData = s_q.bData;
	assign pidA = s_q.pidA;
	assign pidB = s_q.pidB;
	assign audMaskA = s_q.audA;
	assign audMaskB = s_q.audB;
	assign ancOnB = s_q.ancB;
	assign frameStart = s_q.frame;
	assign progOut = s_q.prog;
	assign hScroll = s_q.hOff;
	assign vScroll = s_q.vOff;
	assign gradH = s_q.gradH;
	assign gradV = s_q.gradV;
	assign patternProj = s_q.proj;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_force422;
		isProgFmt(s_q.fmt) && $stable(s_q.fmt) |=> s_q.effSt == CVT_S_YCC422_10;
	endproperty
	a_force422: assert property (p_force422) else $error("progressive 1080 not forced to 422");
	property p_projXyz;
		s_q.proj && $stable(s_q.fmt) |=> s_q.effSt == CVT_S_XYZ12;
	endproperty
	a_projXyz: assert property (p_projXyz) else $error("projector set not XYZ");
	property p_convReset;
		regWr && regAddr == `CVT_A_CTRL && regWdata[`CVT_B_CONV] && !s_q.convEn |=> !s_q.proj;
	endproperty
	a_convReset: assert property (p_convReset) else $error("pattern set kept on entry");
	property p_noInput;
		s_q.convEn && !inLock |=> s_q.noIn && !s_q.fmtErr;
	endproperty
	a_noInput: assert property (p_noInput) else $error("missing input not flagged alone");
	property p_period;
		s_q.period >= 5'd1 && s_q.period <= 5'(`CVT_PER_MAX);
	endproperty
	a_period: assert property (p_period) else $error("scroll period out of range");
	property p_hStep;
		s_q.hStep[1:0] == 2'b00 && $signed(s_q.hStep) <= `CVT_SCR_MAX && $signed(s_q.hStep) >= -`CVT_SCR_MAX;
	endproperty
	a_hStep: assert property (p_hStep) else $error("h step illegal");
	property p_skew;
		$signed(s_q.skew) <= `CVT_SKEW_MAX && $signed(s_q.skew) >= -`CVT_SKEW_MAX;
	endproperty
	a_skew: assert property (p_skew) else $error("skew beyond limit");
	property p_audB;
		s_q.aud == CVT_AUD_B && !isProgFmt(s_q.fmt) && s_q.effSt != CVT_S_YCC422_10
			##1 $stable(s_q.aud) && $stable(s_q.fmt) && $stable(s_q.effSt)
			|=> audMaskA == 4'h0 && audMaskB == 4'h3;
	endproperty
	a_audB: assert property (p_audB) else $error("secondary-only audio misrouted");
	property p_gradH;
		gradH >= 12'(`CVT_GRAD_MIN) && gradH <= 12'(`CVT_GRADH_MAX);
	endproperty
	a_gradH: assert property (p_gradH) else $error("h gradient out of range");
	c_prog: cover property (progOut && frameStart);
	c_single: cover property (s_q.effSt == CVT_S_YCC422_10 && !progOut && linkAValid);
	c_scroll: cover property (frameStart ##[1:4] $changed(hScroll));
endmodule // cvt_dual_link

// ### src/cvt_map.svh
`ifndef CVT_MAP_SVH
`define CVT_MAP_SVH
// register word indices
`define CVT_A_CTRL 4'h0
`define CVT_A_FMT 4'h1
`define CVT_A_SKEW 4'h2
`define CVT_A_HSTEP 4'h3
`define CVT_A_VSTEP 4'h4
`define CVT_A_PERIOD 4'h5
`define CVT_A_GRADH 4'h6
`define CVT_A_GRADV 4'h7
`define CVT_A_STATUS 4'h8
// control field positions
`define CVT_B_CONV 0
`define CVT_B_LUMA 1
`define CVT_B_AUD 2
`define CVT_B_PROJ 4
`define CVT_B_RND 5
`define CVT_B_ALPHA 6
`define CVT_B_REQST 4
// reset values
`define CVT_RST_PERIOD 5'h01
`define CVT_RST_GRAD 12'h010
// timing
`define CVT_CLK_PS 20000
`define CVT_STEP_PS 13500
`define CVT_SKEW_LIM_PS 202000
`define CVT_SKEW_CYC ((`CVT_STEP_PS + `CVT_CLK_PS - 1) / `CVT_CLK_PS)
`define CVT_SKEW_MAX (`CVT_SKEW_LIM_PS / `CVT_STEP_PS)
// limits
`define CVT_SCR_MAX 252
`define CVT_PER_MAX 16
`define CVT_GRAD_MIN 16
`define CVT_GRADH_MAX 1913
`define CVT_GRADV_1080 2880
`define CVT_GRADV_1556 2404
// levels and ids; payload bytes are arbitrary
`define CVT_PID_SINGLE 8'h85
`define CVT_PID_DUAL 8'h8A
`define CVT_BLANK 12'h100
`define CVT_CHR_MID 2048
`define CVT_FLAT_SPAN 3504
`define CVT_LFSR_SEED 16'hACE1
// colour coefficients, scaled by 1024
`define CVT_K_RCR 1613
`define CVT_K_GCB 192
`define CVT_K_GCR 479
`define CVT_K_BCB 1900
`define CVT_XR 422
`define CVT_XG 366
`define CVT_XB 185
`define CVT_YR 218
`define CVT_YG 732
`define CVT_YB 74
`define CVT_ZR 20
`define CVT_ZG 122
`define CVT_ZB 973
`endif

// ### src/cvt_pkg.sv
package cvt_pkg;
	typedef enum logic [3:0] {
		CVT_F_I60 = 4'h0, CVT_F_I5994 = 4'h1, CVT_F_I50 = 4'h2,
		CVT_F_P60 = 4'h3, CVT_F_P5994 = 4'h4, CVT_F_P50 = 4'h5,
		CVT_F_PLOW = 4'h6, CVT_F_2K1080 = 4'h7, CVT_F_2K1556 = 4'h8
	} cvt_fmt_t;
	typedef enum logic [3:0] {
		CVT_S_GBR12 = 4'h0, CVT_S_GBR10 = 4'h1, CVT_S_GBRA10 = 4'h2,
		CVT_S_YCC444_12 = 4'h3, CVT_S_YCC444_10 = 4'h4, CVT_S_YCCA444_10 = 4'h5,
		CVT_S_YCC422_12 = 4'h6, CVT_S_YCC422_10 = 4'h7, CVT_S_YCCA422_12 = 4'h8,
		CVT_S_XYZ12 = 4'h9
	} cvt_smp_t;
	typedef enum logic [1:0] {
		CVT_AUD_A = 2'h0, CVT_AUD_B = 2'h1, CVT_AUD_AB = 2'h2
	} cvt_aud_t;
endpackage

// ### testbench/cvt_video_src.sv
`timescale 1ns/1ns
module cvt_video_src (
	input wire logic core_clk, // sample clock
	output logic inValid, // sample valid
	output logic [9:0] inLuma, // luma
	output logic [9:0] inChroma, // Cb or Cr
	output logic inCbFlag, // chroma is Cb
	output logic inFieldStart, // first sample of field
	output logic inLock, // source present
	output cvt_pkg::cvt_fmt_t inFormat // sent format
);
	import cvt_pkg::*;
	initial begin
		inValid = 1'b0;
		inLuma = 10'h000;
		inChroma = 10'h200;
		inCbFlag = 1'b1;
		inFieldStart = 1'b0;
		inLock = 1'b0;
		inFormat = CVT_F_I5994;
	end
	task automatic set_src(input logic l, input cvt_fmt_t f);
		@(posedge core_clk);
		inLock <= l;
		inFormat <= f;
	endtask
	// even pixel carries Cb, the next one Cr
	task automatic send_field(input int n, input logic [9:0] y);
		@(posedge core_clk);
		inFieldStart <= 1'b1;
		for (int i = 0; i < n; i++) begin
			inValid <= 1'b1;
			inLuma <= y;
			inChroma <= 10'h200 + 10'(i * 8);
			inCbFlag <= ~i[0];
			@(posedge core_clk);
			inFieldStart <= 1'b0;
		end
		inValid <= 1'b0;
		// idle words inverted so a stale sample cannot pass as fresh
		inLuma <= ~y;
		inChroma <= ~inChroma;
	endtask
endmodule // cvt_video_src

// ### testbench/cvt_dual_link_tb_top.sv
`timescale 1ns/1ns
`include "cvt_map.svh"
module cvt_dual_link_tb_top;
	import cvt_pkg::*;
	logic core_clk, resetn, regWr, regRd;
	logic [3:0] regAddr;
	logic [15:0] regWdata, regRdata;
	logic inValid, inCbFlag, inFieldStart, inLock;
	logic [9:0] inLuma, inChroma;
	cvt_fmt_t inFormat;
	logic linkAValid, linkBValid, ancOnB, frameStart, progOut, patternProj;
	logic [23:0] linkAData, linkBData;
	logic [7:0] pidA, pidB;
	logic [3:0] audMaskA, audMaskB;
	logic [11:0] hScroll, vScroll, gradH, gradV, h0, v0;
	logic [23:0] bLast;
	int err_total, n_compared, cyc, aRise, bRise, frames;
	bit abDiff, lowBad, bSeen;

	cvt_dual_link #(.DLY_DEPTH(16)) u_dut (.core_clk, .resetn, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .inValid, .inLuma, .inChroma, .inCbFlag, .inFieldStart, .inLock, .inFormat,
		.linkAValid, .linkAData, .linkBValid, .linkBData, .pidA, .pidB, .audMaskA, .audMaskB,
		.ancOnB, .frameStart, .progOut, .hScroll, .vScroll, .gradH, .gradV, .patternProj);
	cvt_video_src u_src (.core_clk, .inValid, .inLuma, .inChroma, .inCbFlag, .inFieldStart,
		.inLock, .inFormat);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (frameStart) frames <= frames + 1;
		if (linkAValid && aRise < 0) aRise <= cyc;
		if (linkBValid && bRise < 0) bRise <= cyc;
		if (linkBValid) bSeen <= 1'b1;
		if (linkBValid) bLast <= linkBData;
		if (linkAValid && linkBValid && linkAData !== linkBData) abDiff <= 1'b1;
		if (linkAValid && (linkAData[13:12] !== 2'b00 || linkAData[1:0] !== 2'b00)) lowBad <= 1'b1;
	end
	task automatic mon_clr;
		aRise = -1;
		bRise = -1;
		frames = 0;
		bSeen = 1'b0;
		abDiff = 1'b0;
		lowBad = 1'b0;
		bLast = '0;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic wrchk(input string s, input logic [3:0] a, input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] e);
		logic [15:0] d;
		wr(a, w);
		rd(a, d);
		chk(s, d & m, e);
	endtask
	// status and structure settle up to two cycles after a write
	task automatic stat(input logic [15:0] m, input logic [15:0] e);
		logic [15:0] d;
		repeat (3) @(posedge core_clk);
		rd(`CVT_A_STATUS, d);
		chk("status", d & m, e);
	endtask
	task automatic settle;
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	task automatic t_reset;
		logic [15:0] d;
		rd(`CVT_A_PERIOD, d);
		chk("period", d, 16'h0001);
		rd(4'hF, d);
		chk("unmapped", d, 16'h0000);
		chk("pidA", pidA, 8'h8A);
		chk("gradH", gradH, 12'h010);
		chk("gradV", gradV, 12'h010);
	endtask
	task automatic t_clamp;
		wrchk("period", `CVT_A_PERIOD, 16'h0000, 16'h001F, 16'h0001);
		wrchk("period", `CVT_A_PERIOD, 16'h0011, 16'h001F, 16'h0010);
		wrchk("gradH", `CVT_A_GRADH, 16'h000F, 16'h0FFF, 16'h0010);
		wrchk("gradH", `CVT_A_GRADH, 16'h07D0, 16'h0FFF, 16'h0779);
		chk("gradH", gradH, 12'h779);
		wrchk("hstep", `CVT_A_HSTEP, 16'h0006, 16'h01FF, 16'h0004);
		wrchk("hstep", `CVT_A_HSTEP, 16'h00FF, 16'h01FF, 16'h00FC);
		wrchk("hstep", `CVT_A_HSTEP, 16'h0101, 16'h01FF, 16'h0104);
		wrchk("hstep", `CVT_A_HSTEP, 16'h0102, 16'h01FF, 16'h0104);
		wrchk("vstep", `CVT_A_VSTEP, 16'h00FF, 16'h01FF, 16'h00FC);
		wrchk("vstep", `CVT_A_VSTEP, 16'h0101, 16'h01FF, 16'h0104);
		wrchk("skew", `CVT_A_SKEW, 16'h000F, 16'h001F, 16'h000E);
		wrchk("skew", `CVT_A_SKEW, 16'h0011, 16'h001F, 16'h0012);
		wr(`CVT_A_FMT, 16'h0008);
		wrchk("gradV", `CVT_A_GRADV, 16'h0BB8, 16'h0FFF, 16'h0964);
		wr(`CVT_A_FMT, 16'h0007);
		wrchk("gradV", `CVT_A_GRADV, 16'h0BB8, 16'h0FFF, 16'h0B40);
		chk("gradV", gradV, 12'hB40);
	endtask
	task automatic t_proj;
		wrchk("xyz", `CVT_A_FMT, 16'h0097, 16'h00FF, 16'h0097);
		// request is kept, outside 2K and the P60/P5994/P50 formats the effective structure falls back to GBR 12
		wrchk("xyz", `CVT_A_FMT, 16'h0091, 16'h00FF, 16'h0091);
		stat(16'h0078, 16'h0000);
		wrchk("proj", `CVT_A_CTRL, 16'h0010, 16'h0010, 16'h0000);
		wr(`CVT_A_FMT, 16'h0007);
		wr(`CVT_A_CTRL, 16'h0010);
		stat(16'h0078, 16'h0048);
		chk("proj", patternProj, 1'b1);
		wr(`CVT_A_CTRL, 16'h0011);
		stat(16'h007F, 16'h0001);
		chk("proj", patternProj, 1'b0);
	endtask
	task automatic t_status;
		wr(`CVT_A_FMT, 16'h0003);
		u_src.set_src(1'b0, CVT_F_I60);
		stat(16'h0079, 16'h0039);
		u_src.set_src(1'b1, CVT_F_I5994);
		stat(16'h0003, 16'h0002);
		u_src.set_src(1'b1, CVT_F_I60);
		stat(16'h0003, 16'h0000);
		wr(`CVT_A_FMT, 16'h0031);
		wr(`CVT_A_CTRL, 16'h0003);
		stat(16'h0004, 16'h0004);
		wr(`CVT_A_FMT, 16'h0001);
		stat(16'h0004, 16'h0000);
	endtask
	task automatic t_audio;
		logic [7:0] exp [3] = '{8'h3C, 8'h03, 8'h33};
		u_src.set_src(1'b1, CVT_F_I5994);
		for (int a = 0; a < 3; a++) begin
			wr(`CVT_A_CTRL, 16'h0001 | 16'(a << 2));
			settle();
			chk("audA", audMaskA, exp[a][7:4]);
			chk("audB", audMaskB, exp[a][3:0]);
		end
		wr(`CVT_A_FMT, 16'h0071);
		mon_clr();
		repeat (2) u_src.send_field(6, 10'h155);
		settle();
		chk("audA", audMaskA, 4'hF);
		chk("audB", audMaskB, 4'h0);
		chk("ancB", ancOnB, 1'b0);
		chk("pidB", pidB, 8'h85);
		chk("linkB", bSeen, 1'b0);
		chk("linkA", aRise >= 0, 1'b1);
		chk("frames", frames, 1);
		wr(`CVT_A_FMT, 16'h0061);
		mon_clr();
		u_src.send_field(12, 10'h3FF);
		settle();
		chk("lowbits", lowBad, 1'b0);
		chk("linkA", aRise >= 0, 1'b1);
	endtask
	task automatic t_prog;
		wr(`CVT_A_PERIOD, 16'h0002);
		wr(`CVT_A_FMT, 16'h0003);
		wr(`CVT_A_SKEW, 16'h0000);
		u_src.set_src(1'b1, CVT_F_I60);
		mon_clr();
		repeat (2) u_src.send_field(8, 10'h0AA);
		settle();
		chk("progOut", progOut, 1'b1);
		chk("frames", frames, 2);
		chk("abDiff", abDiff, 1'b0);
		chk("bSeen", bSeen, 1'b1);
		chk("pidA", pidA, 8'h8A);
		chk("pidB", pidB, 8'h8A);
		wr(`CVT_A_SKEW, 16'h0003);
		mon_clr();
		u_src.send_field(4, 10'h0AA);
		settle();
		chk("skewPos", bRise - aRise, 3);
		wr(`CVT_A_SKEW, 16'h001E);
		mon_clr();
		u_src.send_field(4, 10'h0AA);
		settle();
		chk("skewNeg", aRise - bRise, 2);
	endtask
	task automatic t_scroll;
		wr(`CVT_A_HSTEP, 16'h0008);
		wr(`CVT_A_VSTEP, 16'h01FD);
		#1;
		h0 = hScroll;
		v0 = vScroll;
		repeat (4) u_src.send_field(4, 10'h100);
		settle();
		chk("hScroll", hScroll, h0 + 12'h010);
		chk("vScroll", vScroll, v0 - 12'h006);
		// fixed steps zero, so any movement must come from the random source
		wr(`CVT_A_HSTEP, 16'h0000);
		wr(`CVT_A_VSTEP, 16'h0000);
		wr(`CVT_A_CTRL, 16'h0021);
		#1;
		h0 = hScroll;
		v0 = vScroll;
		repeat (2) u_src.send_field(4, 10'h100);
		settle();
		chk("rndH", (hScroll - h0) & 12'h003, 12'h000);
		chk("rndMove", {hScroll, vScroll} != {h0, v0}, 1'b1);
	endtask
	task automatic t_alpha;
		wr(`CVT_A_FMT, 16'h0021);
		wr(`CVT_A_CTRL, 16'h02C1);
		mon_clr();
		u_src.send_field(8, 10'h100);
		settle();
		chk("alphaFlat", bLast[11:0], 12'hEB0);
		wr(`CVT_A_FMT, 16'h0001);
		mon_clr();
		u_src.send_field(8, 10'h100);
		settle();
		chk("alphaBlank", bLast[11:0], 12'h100);
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		cyc = 0;
		mon_clr();
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_clamp();
		t_proj();
		t_status();
		t_audio();
		t_prog();
		t_scroll();
		t_alpha();
		end_of_test();
	end
	// whole run needs about four hundred cycles, limit is fifty times that
	initial begin
		#400000;
		err_total++;
		end_of_test();
	end
endmodule // cvt_dual_link_tb_top
